// File: hdl/pcs_consts.svh
// Purpose: shared constants of the bus signalling ends
// Assumes: included by bare name
// Notes: status bit positions index usr_sts / h_sts
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_CMD_MEM_RD 4'h6
`define PCS_CMD_MEM_WR 4'h7
`define PCS_CMD_CFG_RD 4'ha
`define PCS_CMD_CFG_WR 4'hb
// data-phase cycles without a device select before the master gives up
`define PCS_DEVSEL_WAIT 3'h5
`define PCS_STS_W 3
`define PCS_STS_ABORT 0
`define PCS_STS_RETRY 1
`define PCS_STS_PERR 2
`endif

// File: hdl/pcs_pkg.sv
// Purpose: state types of the bus signalling ends
// Assumes: nothing
// Notes: none
package pcs_pkg;
  typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN, M_POST} pcs_mst_t;
  typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN, T_WAIT} pcs_tgt_t;
endpackage : pcs_pkg

// File: hdl/pcs_bus_if.sv
// Purpose: shared bus between the device end and the host end
// Assumes: undriven lines float high through pull-ups
// Notes: each shared line but serr_n, req_n, gnt_n and idsel has per-party value and enable
`timescale 1ns/1ps
interface pcs_bus_if;
  logic [31:0] dev_ad_o, host_ad_o, ad;
  logic dev_ad_oe, host_ad_oe;
  logic [3:0] dev_cbe_n_o, host_cbe_n_o, cbe_n;
  logic dev_cbe_n_oe, host_cbe_n_oe;
  logic dev_par_o, host_par_o, dev_par_oe, host_par_oe, par;
  logic dev_frame_n_o, host_frame_n_o, dev_frame_n_oe, host_frame_n_oe, frame_n;
  logic dev_irdy_n_o, host_irdy_n_o, dev_irdy_n_oe, host_irdy_n_oe, irdy_n;
  logic dev_trdy_n_o, host_trdy_n_o, dev_trdy_n_oe, host_trdy_n_oe, trdy_n;
  logic dev_stop_n_o, host_stop_n_o, dev_stop_n_oe, host_stop_n_oe, stop_n;
  logic dev_devsel_n_o, host_devsel_n_o, dev_devsel_n_oe, host_devsel_n_oe, devsel_n;
  logic dev_perr_n_o, host_perr_n_o, dev_perr_n_oe, host_perr_n_oe, perr_n;
  logic dev_serr_n_o, dev_serr_n_oe, serr_n;
  logic req_n, gnt_n, idsel;

  assign ad = dev_ad_oe ? dev_ad_o : (host_ad_oe ? host_ad_o : 32'hffff_ffff);
  assign cbe_n = dev_cbe_n_oe ? dev_cbe_n_o : (host_cbe_n_oe ? host_cbe_n_o : 4'hf);
  assign par = dev_par_oe ? dev_par_o : (host_par_oe ? host_par_o : 1'b1);
  assign frame_n = dev_frame_n_oe ? dev_frame_n_o : (host_frame_n_oe ? host_frame_n_o : 1'b1);
  assign irdy_n = dev_irdy_n_oe ? dev_irdy_n_o : (host_irdy_n_oe ? host_irdy_n_o : 1'b1);
  assign trdy_n = dev_trdy_n_oe ? dev_trdy_n_o : (host_trdy_n_oe ? host_trdy_n_o : 1'b1);
  assign stop_n = dev_stop_n_oe ? dev_stop_n_o : (host_stop_n_oe ? host_stop_n_o : 1'b1);
  assign devsel_n = dev_devsel_n_oe ? dev_devsel_n_o :
                    (host_devsel_n_oe ? host_devsel_n_o : 1'b1);
  assign perr_n = dev_perr_n_oe ? dev_perr_n_o : (host_perr_n_oe ? host_perr_n_o : 1'b1);
  assign serr_n = dev_serr_n_oe ? dev_serr_n_o : 1'b1;

  modport dev (
    output dev_ad_o, dev_ad_oe, dev_cbe_n_o, dev_cbe_n_oe, dev_par_o, dev_par_oe,
    output dev_frame_n_o, dev_frame_n_oe, dev_irdy_n_o, dev_irdy_n_oe,
    output dev_trdy_n_o, dev_trdy_n_oe, dev_stop_n_o, dev_stop_n_oe,
    output dev_devsel_n_o, dev_devsel_n_oe, dev_perr_n_o, dev_perr_n_oe,
    output dev_serr_n_o, dev_serr_n_oe, req_n,
    input ad, cbe_n, par, frame_n, irdy_n, trdy_n, stop_n, devsel_n, perr_n, gnt_n, idsel
  );
  modport host (
    output host_ad_o, host_ad_oe, host_cbe_n_o, host_cbe_n_oe, host_par_o, host_par_oe,
    output host_frame_n_o, host_frame_n_oe, host_irdy_n_o, host_irdy_n_oe,
    output host_trdy_n_o, host_trdy_n_oe, host_stop_n_o, host_stop_n_oe,
    output host_devsel_n_o, host_devsel_n_oe, host_perr_n_o, host_perr_n_oe, gnt_n, idsel,
    input ad, cbe_n, par, frame_n, irdy_n, trdy_n, stop_n, devsel_n, perr_n, serr_n, req_n
  );
endinterface : pcs_bus_if

// File: hdl/pcs_dev.sv
// Purpose: device end of the bus, master and target, user port on sys_clk
// Assumes: bus logic on pci_clk; user port fields held while usr_busy
// Notes: single data phase per transaction
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_dev import pcs_pkg::*; #(
  parameter logic [31:0] MEM_BASE = 32'h0001_0000
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pci_clk,
  pcs_bus_if.dev bus,
  input wire logic usr_start,
  input wire logic [3:0] usr_cmd,
  input wire logic [31:0] usr_addr,
  input wire logic [31:0] usr_wdata,
  input wire logic [3:0] usr_be_n,
  output logic usr_busy,
  output logic usr_done,
  output logic [31:0] usr_rdata,
  output logic [`PCS_STS_W-1:0] usr_sts,
  output logic tgt_wr_valid,
  output logic [31:0] tgt_wr_addr,
  output logic [31:0] tgt_wr_data
);
  if (MEM_BASE[3:0] != 4'h0) begin : g_chk
    $error("MEM_BASE must be 16-byte aligned");
  end

  // sys_clk side
  logic [3:0] u_cmd, next_u_cmd, u_be_n, next_u_be_n;
  logic [31:0] u_addr, next_u_addr, u_wdata, next_u_wdata;
  logic u_busy, next_u_busy, req_tgl, next_req_tgl;
  logic [2:0] done_s, ev_s;
  logic next_usr_done, next_tgt_wr_valid;
  logic [31:0] next_usr_rdata, next_tgt_wr_addr, next_tgt_wr_data;
  logic [`PCS_STS_W-1:0] next_usr_sts;
  // pci_clk side
  pcs_mst_t m_state, next_m_state;
  pcs_tgt_t t_state, next_t_state;
  logic [2:0] req_l, m_cnt, next_m_cnt, t_idx, next_t_idx;
  logic done_tgl, next_done_tgl, ev_tgl, next_ev_tgl;
  logic [31:0] m_rdata, next_m_rdata, ev_addr, next_ev_addr, ev_data, next_ev_data;
  logic [31:0] t_addr, next_t_addr;
  logic [`PCS_STS_W-1:0] m_sts, next_m_sts;
  logic t_wr, next_t_wr;
  logic [31:0] mem [8];
  logic [31:0] next_mem [8];
  logic apar_arm, next_apar_arm, apar_val, next_apar_val;
  logic chk_arm, next_chk_arm, chk_val, next_chk_val;
  logic [1:0] perr_drv, next_perr_drv;
  logic serr_drv, next_serr_drv, par, next_par, par_oe, next_par_oe;
  logic m_wr, ad_oe, par_bad, cfg_hit, mem_hit;

  always_comb begin
    next_u_cmd = u_cmd;
    next_u_addr = u_addr;
    next_u_wdata = u_wdata;
    next_u_be_n = u_be_n;
    next_u_busy = u_busy;
    next_req_tgl = req_tgl;
    next_usr_done = 1'b0;
    next_usr_rdata = usr_rdata;
    next_usr_sts = usr_sts;
    next_tgt_wr_valid = 1'b0;
    next_tgt_wr_addr = tgt_wr_addr;
    next_tgt_wr_data = tgt_wr_data;
    if (usr_start && !u_busy) begin
      next_u_cmd = usr_cmd;
      next_u_addr = usr_addr;
      next_u_wdata = usr_wdata;
      next_u_be_n = usr_be_n;
      next_u_busy = 1'b1;
      next_req_tgl = !req_tgl;
    end
    if (done_s[2] != done_s[1]) begin
      next_usr_done = 1'b1;
      next_usr_rdata = m_rdata;
      next_usr_sts = m_sts;
      next_u_busy = 1'b0;
    end
    if (ev_s[2] != ev_s[1]) begin
      next_tgt_wr_valid = 1'b1;
      next_tgt_wr_addr = ev_addr;
      next_tgt_wr_data = ev_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      u_cmd <= 4'h0;
      u_addr <= 32'h0;
      u_wdata <= 32'h0;
      u_be_n <= 4'hf;
      u_busy <= 1'b0;
      req_tgl <= 1'b0;
      done_s <= 3'h0;
      ev_s <= 3'h0;
      usr_done <= 1'b0;
      usr_rdata <= 32'h0;
      usr_sts <= '0;
      tgt_wr_valid <= 1'b0;
      tgt_wr_addr <= 32'h0;
      tgt_wr_data <= 32'h0;
    end else begin
      u_cmd <= next_u_cmd;
      u_addr <= next_u_addr;
      u_wdata <= next_u_wdata;
      u_be_n <= next_u_be_n;
      u_busy <= next_u_busy;
      req_tgl <= next_req_tgl;
      done_s <= {done_s[1:0], done_tgl};
      ev_s <= {ev_s[1:0], ev_tgl};
      usr_done <= next_usr_done;
      usr_rdata <= next_usr_rdata;
      usr_sts <= next_usr_sts;
      tgt_wr_valid <= next_tgt_wr_valid;
      tgt_wr_addr <= next_tgt_wr_addr;
      tgt_wr_data <= next_tgt_wr_data;
    end
  end
  assign usr_busy = u_busy;

  // bus-facing logic, all on pci_clk rising edges
  assign m_wr = u_cmd[0];
  assign ad_oe = (m_state == M_ADDR) || (m_state == M_DATA && m_wr) ||
                 (t_state == T_DATA && !t_wr);
  assign par_bad = chk_arm && (chk_val != bus.par);
  assign cfg_hit = bus.idsel && (bus.cbe_n == `PCS_CMD_CFG_RD ||
                   bus.cbe_n == `PCS_CMD_CFG_WR);
  assign mem_hit = (bus.cbe_n == `PCS_CMD_MEM_RD || bus.cbe_n == `PCS_CMD_MEM_WR) &&
                   bus.ad[31:4] == MEM_BASE[31:4];

  always_comb begin
    next_m_state = m_state;
    next_m_cnt = m_cnt;
    next_m_rdata = m_rdata;
    next_m_sts = m_sts;
    next_done_tgl = done_tgl;
    next_t_state = t_state;
    next_t_idx = t_idx;
    next_t_addr = t_addr;
    next_t_wr = t_wr;
    next_ev_tgl = ev_tgl;
    next_ev_addr = ev_addr;
    next_ev_data = ev_data;
    next_mem = mem;
    next_apar_arm = 1'b0;
    next_apar_val = apar_val;
    next_chk_arm = 1'b0;
    next_chk_val = chk_val;
    next_serr_drv = apar_arm && (apar_val != bus.par);
    next_perr_drv = {perr_drv[0], par_bad};
    next_par = ^{bus.ad, bus.cbe_n};
    next_par_oe = ad_oe;
    case (m_state)
      M_IDLE: if (req_l[2] != req_l[1]) next_m_state = M_REQ;
      M_REQ: begin
        if (!bus.gnt_n && bus.frame_n && bus.irdy_n) begin
          next_m_state = M_ADDR;
          next_m_cnt = 3'h0;
          next_m_sts = '0;
        end
      end
      M_ADDR: next_m_state = M_DATA;
      M_DATA: begin
        if (!bus.trdy_n) begin
          next_m_state = M_TURN;
          next_m_rdata = bus.ad;
          next_chk_arm = !m_wr;
          next_chk_val = ^{bus.ad, bus.cbe_n};
        end else if (!bus.stop_n) begin
          next_m_state = M_TURN;
          next_m_sts[`PCS_STS_RETRY] = 1'b1;
        end else if (bus.devsel_n) begin
          if (m_cnt == `PCS_DEVSEL_WAIT - 3'h1) begin
            next_m_state = M_TURN;
            next_m_sts[`PCS_STS_ABORT] = 1'b1;
          end else begin
            next_m_cnt = m_cnt + 3'h1;
          end
        end
      end
      M_TURN, M_POST: begin
        if ((m_wr && !bus.perr_n) || par_bad) next_m_sts[`PCS_STS_PERR] = 1'b1;
        if (m_state == M_TURN) begin
          next_m_state = M_POST;
        end else begin
          next_m_state = M_IDLE;
          next_done_tgl = !done_tgl;
        end
      end
      default: next_m_state = M_IDLE;
    endcase
    case (t_state)
      T_IDLE: begin
        if (!bus.frame_n && !bus.dev_frame_n_oe) begin
          next_apar_arm = 1'b1;
          next_apar_val = ^{bus.ad, bus.cbe_n};
          next_t_addr = bus.ad;
          next_t_wr = bus.cbe_n[0];
          next_t_idx = {mem_hit, bus.ad[3:2]};
          next_t_state = (cfg_hit || mem_hit) ? T_DATA : T_WAIT;
        end
      end
      T_DATA: begin
        if (!bus.irdy_n) begin
          next_t_state = T_TURN;
          if (t_wr) begin
            for (int b = 0; b < 4; b++) begin
              if (!bus.cbe_n[b]) next_mem[t_idx][8*b +: 8] = bus.ad[8*b +: 8];
            end
            next_chk_arm = 1'b1;
            next_chk_val = ^{bus.ad, bus.cbe_n};
            next_ev_tgl = !ev_tgl;
            next_ev_addr = t_addr;
            next_ev_data = bus.ad;
          end
        end
      end
      T_TURN: next_t_state = T_WAIT;
      T_WAIT: if (bus.frame_n && bus.irdy_n) next_t_state = T_IDLE;
      default: next_t_state = T_IDLE;
    endcase
  end

  always_ff @(posedge pci_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_l <= 3'h0;
      m_state <= M_IDLE;
      m_cnt <= 3'h0;
      m_rdata <= 32'h0;
      m_sts <= '0;
      done_tgl <= 1'b0;
      t_state <= T_IDLE;
      t_idx <= 3'h0;
      t_addr <= 32'h0;
      t_wr <= 1'b0;
      ev_tgl <= 1'b0;
      ev_addr <= 32'h0;
      ev_data <= 32'h0;
      for (int i = 0; i < 8; i++) mem[i] <= 32'h0;
      apar_arm <= 1'b0;
      apar_val <= 1'b0;
      chk_arm <= 1'b0;
      chk_val <= 1'b0;
      perr_drv <= 2'h0;
      serr_drv <= 1'b0;
      par <= 1'b0;
      par_oe <= 1'b0;
    end else begin
      req_l <= {req_l[1:0], req_tgl};
      m_state <= next_m_state;
      m_cnt <= next_m_cnt;
      m_rdata <= next_m_rdata;
      m_sts <= next_m_sts;
      done_tgl <= next_done_tgl;
      t_state <= next_t_state;
      t_idx <= next_t_idx;
      t_addr <= next_t_addr;
      t_wr <= next_t_wr;
      ev_tgl <= next_ev_tgl;
      ev_addr <= next_ev_addr;
      ev_data <= next_ev_data;
      mem <= next_mem;
      apar_arm <= next_apar_arm;
      apar_val <= next_apar_val;
      chk_arm <= next_chk_arm;
      chk_val <= next_chk_val;
      perr_drv <= next_perr_drv;
      serr_drv <= next_serr_drv;
      par <= next_par;
      par_oe <= next_par_oe;
    end
  end

  assign bus.req_n = !(m_state == M_REQ);
  assign bus.dev_frame_n_o = !(m_state == M_ADDR);
  assign bus.dev_frame_n_oe = (m_state == M_ADDR) || (m_state == M_DATA);
  assign bus.dev_irdy_n_o = !(m_state == M_DATA);
  assign bus.dev_irdy_n_oe = (m_state == M_DATA) || (m_state == M_TURN);
  assign bus.dev_ad_o = (m_state == M_ADDR) ? u_addr :
                        ((m_state == M_DATA) ? u_wdata : mem[t_idx]);
  assign bus.dev_ad_oe = ad_oe;
  assign bus.dev_cbe_n_o = (m_state == M_ADDR) ? u_cmd : u_be_n;
  assign bus.dev_cbe_n_oe = (m_state == M_ADDR) || (m_state == M_DATA);
  assign bus.dev_par_o = par;
  assign bus.dev_par_oe = par_oe;
  assign bus.dev_trdy_n_o = !(t_state == T_DATA);
  assign bus.dev_trdy_n_oe = (t_state == T_DATA) || (t_state == T_TURN);
  assign bus.dev_devsel_n_o = !(t_state == T_DATA);
  assign bus.dev_devsel_n_oe = (t_state == T_DATA) || (t_state == T_TURN);
  assign bus.dev_stop_n_o = !(t_state == T_DATA);
  assign bus.dev_stop_n_oe = (t_state == T_DATA) || (t_state == T_TURN);
  assign bus.dev_perr_n_o = !perr_drv[0];
  assign bus.dev_perr_n_oe = |perr_drv;
  assign bus.dev_serr_n_o = 1'b0;
  assign bus.dev_serr_n_oe = serr_drv;
endmodule : pcs_dev

// File: hdl/pcs_host.sv
// Purpose: host end of the bus: bridge master, memory target and arbiter
// Assumes: user port synchronous to pci_clk; h_cmd/h_addr/h_wdata/h_be_n held while busy
// Notes: single data phase per transaction
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_host import pcs_pkg::*; (
  input wire logic pci_clk,
  input wire logic rst_n,
  pcs_bus_if.host bus,
  input wire logic h_start,
  input wire logic [3:0] h_cmd,
  input wire logic [31:0] h_addr,
  input wire logic [31:0] h_wdata,
  input wire logic [3:0] h_be_n,
  output logic h_busy,
  output logic h_done,
  output logic [31:0] h_rdata,
  output logic [`PCS_STS_W-1:0] h_sts
);
  pcs_mst_t m_state, next_m_state;
  pcs_tgt_t t_state, next_t_state;
  logic [2:0] m_cnt, next_m_cnt;
  logic [1:0] t_idx, next_t_idx;
  logic t_wr, next_t_wr, grant, next_grant, par, next_par, par_oe, next_par_oe;
  logic next_h_done, m_wr, ad_oe, cfg;
  logic [31:0] next_h_rdata;
  logic [`PCS_STS_W-1:0] next_h_sts;
  logic [31:0] mem [4];
  logic [31:0] next_mem [4];

  assign m_wr = h_cmd[0];
  assign cfg = (h_cmd == `PCS_CMD_CFG_RD) || (h_cmd == `PCS_CMD_CFG_WR);
  assign ad_oe = (m_state == M_ADDR) || (m_state == M_DATA && m_wr) ||
                 (t_state == T_DATA && !t_wr);

  always_comb begin
    next_m_state = m_state;
    next_m_cnt = m_cnt;
    next_h_done = 1'b0;
    next_h_rdata = h_rdata;
    next_h_sts = h_sts;
    next_t_state = t_state;
    next_t_idx = t_idx;
    next_t_wr = t_wr;
    next_mem = mem;
    next_grant = grant;
    next_par = ^{bus.ad, bus.cbe_n};
    next_par_oe = ad_oe;
    // arbiter: grant only while requested and the host master is idle
    if (bus.req_n) next_grant = 1'b0;
    else if (m_state == M_IDLE && !h_start) next_grant = 1'b1;
    case (m_state)
      M_IDLE: begin
        if (h_start && !grant && bus.req_n && bus.frame_n && bus.irdy_n) begin
          next_m_state = M_ADDR;
          next_m_cnt = 3'h0;
          next_h_sts = '0;
        end
      end
      M_ADDR: next_m_state = M_DATA;
      M_DATA: begin
        if (!bus.trdy_n) begin
          next_m_state = M_TURN;
          next_h_rdata = bus.ad;
        end else if (!bus.stop_n) begin
          next_m_state = M_TURN;
          next_h_sts[`PCS_STS_RETRY] = 1'b1;
        end else if (bus.devsel_n) begin
          if (m_cnt == `PCS_DEVSEL_WAIT - 3'h1) begin
            next_m_state = M_TURN;
            next_h_sts[`PCS_STS_ABORT] = 1'b1;
          end else begin
            next_m_cnt = m_cnt + 3'h1;
          end
        end
      end
      M_TURN, M_POST: begin
        if ((m_wr && !bus.perr_n) || !bus.serr_n) next_h_sts[`PCS_STS_PERR] = 1'b1;
        if (m_state == M_TURN) begin
          next_m_state = M_POST;
        end else begin
          next_m_state = M_IDLE;
          next_h_done = 1'b1;
        end
      end
      default: next_m_state = M_IDLE;
    endcase
    case (t_state)
      T_IDLE: begin
        if (!bus.frame_n && !bus.host_frame_n_oe) begin
          next_t_idx = bus.ad[3:2];
          next_t_wr = bus.cbe_n[0];
          next_t_state = (bus.cbe_n == `PCS_CMD_MEM_RD || bus.cbe_n == `PCS_CMD_MEM_WR) ?
                         T_DATA : T_WAIT;
        end
      end
      T_DATA: begin
        if (!bus.irdy_n) begin
          next_t_state = T_TURN;
          if (t_wr) begin
            for (int b = 0; b < 4; b++) begin
              if (!bus.cbe_n[b]) next_mem[t_idx][8*b +: 8] = bus.ad[8*b +: 8];
            end
          end
        end
      end
      T_TURN: next_t_state = T_WAIT;
      T_WAIT: if (bus.frame_n && bus.irdy_n) next_t_state = T_IDLE;
      default: next_t_state = T_IDLE;
    endcase
  end

  always_ff @(posedge pci_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_state <= M_IDLE;
      m_cnt <= 3'h0;
      h_done <= 1'b0;
      h_rdata <= 32'h0;
      h_sts <= '0;
      t_state <= T_IDLE;
      t_idx <= 2'h0;
      t_wr <= 1'b0;
      for (int i = 0; i < 4; i++) mem[i] <= 32'h0;
      grant <= 1'b0;
      par <= 1'b0;
      par_oe <= 1'b0;
    end else begin
      m_state <= next_m_state;
      m_cnt <= next_m_cnt;
      h_done <= next_h_done;
      h_rdata <= next_h_rdata;
      h_sts <= next_h_sts;
      t_state <= next_t_state;
      t_idx <= next_t_idx;
      t_wr <= next_t_wr;
      mem <= next_mem;
      grant <= next_grant;
      par <= next_par;
      par_oe <= next_par_oe;
    end
  end

  assign h_busy = (m_state != M_IDLE);
  assign bus.gnt_n = !grant;
  assign bus.idsel = (m_state == M_ADDR) && cfg;
  assign bus.host_frame_n_o = !(m_state == M_ADDR);
  assign bus.host_frame_n_oe = (m_state == M_ADDR) || (m_state == M_DATA);
  assign bus.host_irdy_n_o = !(m_state == M_DATA);
  assign bus.host_irdy_n_oe = (m_state == M_DATA) || (m_state == M_TURN);
  assign bus.host_ad_o = (m_state == M_ADDR) ? h_addr :
                         ((m_state == M_DATA) ? h_wdata : mem[t_idx]);
  assign bus.host_ad_oe = ad_oe;
  assign bus.host_cbe_n_o = (m_state == M_ADDR) ? h_cmd : h_be_n;
  assign bus.host_cbe_n_oe = (m_state == M_ADDR) || (m_state == M_DATA);
  assign bus.host_par_o = par;
  assign bus.host_par_oe = par_oe;
  assign bus.host_trdy_n_o = !(t_state == T_DATA);
  assign bus.host_trdy_n_oe = (t_state == T_DATA) || (t_state == T_TURN);
  assign bus.host_devsel_n_o = !(t_state == T_DATA);
  assign bus.host_devsel_n_oe = (t_state == T_DATA) || (t_state == T_TURN);
  assign bus.host_stop_n_o = !(t_state == T_DATA);
  assign bus.host_stop_n_oe = (t_state == T_DATA) || (t_state == T_TURN);
  assign bus.host_perr_n_o = 1'b1;
  assign bus.host_perr_n_oe = 1'b0;
endmodule : pcs_host

// File: dv/pcs_checker.sv
// Purpose: protocol checker on the shared bus lines
// Assumes: inputs taken from pcs_bus_if, all in the pci_clk domain
// Notes: both ends are design code, so every line here is design driven
`timescale 1ns/1ps
module pcs_checker (
  input wire logic pci_clk,
  input wire logic rst_n,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  input wire logic par,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic perr_n,
  input wire logic serr_n,
  input wire logic devsel_n,
  input wire logic gnt_n,
  input wire logic idsel,
  input wire logic dev_ad_oe,
  input wire logic host_ad_oe,
  input wire logic dev_frame_n_oe,
  input wire logic host_frame_n_oe,
  input wire logic dev_devsel_n_oe
);
  default clocking cb @(posedge pci_clk); endclocking
  default disable iff (!rst_n);
  a_frame_one_phase: assert property ($fell(frame_n) |=> frame_n && !irdy_n)
    else $error("frame not single cycle or irdy late");
  a_cmd_on_cbe: assert property ($fell(frame_n) |->
    cbe_n inside {4'h6, 4'h7, 4'ha, 4'hb})
    else $error("no valid command on cbe in address phase");
  a_grant_first: assert property ($rose(dev_frame_n_oe) |-> $past(gnt_n) == 1'b0)
    else $error("device started without grant");
  a_par_even: assert property (($past(dev_ad_oe) || $past(host_ad_oe)) |->
    par == ^{$past(ad), $past(cbe_n)})
    else $error("parity not even over previous ad and cbe");
  a_target_release: assert property (!irdy_n && !trdy_n |=> trdy_n && devsel_n)
    else $error("target lines not raised after transfer");
  a_irdy_turn: assert property (!irdy_n && !trdy_n |=> irdy_n)
    else $error("irdy held after transfer");
  a_trdy_selected: assert property (!trdy_n |-> !devsel_n)
    else $error("target ready without device select");
  a_cfg_select: assert property ($fell(frame_n) && host_frame_n_oe && idsel &&
    cbe_n[3:1] == 3'h5 |=> dev_devsel_n_oe)
    else $error("device ignored selected config cycle");
  // both ends compute parity alike, so no error line may ever fall
  a_no_par_err: assert property (perr_n && serr_n)
    else $error("parity error reported on clean traffic");
  a_stop_selected: assert property (!stop_n |-> !devsel_n)
    else $error("stop driven by a target that is not selected");
endmodule : pcs_checker

// File: dv/tb_top.sv
// Purpose: self-checking bench joining device end and host end
// Assumes: host target holds plain memory words, device config words are writable
// Notes: single data phase transfers only
`timescale 1ns/1ps
`include "pcs_consts.svh"
module tb_top;
  localparam logic [31:0] BASE = 32'h0001_0000;
  logic sys_clk = 1'b0, pci_clk = 1'b0, rst_n = 1'b0;
  logic usr_start = 1'b0, h_start = 1'b0, usr_busy, usr_done, tgt_wr_valid, h_busy, h_done;
  logic [3:0] usr_cmd = 4'h0, usr_be_n = 4'h0, h_cmd = 4'h0, h_be_n = 4'h0;
  logic [31:0] usr_addr = 32'h0, usr_wdata = 32'h0, h_addr = 32'h0, h_wdata = 32'h0;
  logic [31:0] usr_rdata, tgt_wr_addr, tgt_wr_data, h_rdata, wr_a = 32'h0, wr_d = 32'h0;
  logic [2:0] usr_sts, h_sts;
  int errors = 0, num_checks = 0;
  pcs_bus_if bus();
  pcs_dev #(.MEM_BASE(BASE)) i_pcs_dev (.bus(bus.dev), .*);
  pcs_host i_pcs_host (.bus(bus.host), .*);
  pcs_checker i_pcs_checker (.pci_clk(pci_clk), .rst_n(rst_n), .ad(bus.ad), .cbe_n(bus.cbe_n),
    .par(bus.par), .frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .trdy_n(bus.trdy_n),
    .stop_n(bus.stop_n), .perr_n(bus.perr_n), .serr_n(bus.serr_n),
    .devsel_n(bus.devsel_n), .gnt_n(bus.gnt_n), .idsel(bus.idsel), .dev_ad_oe(bus.dev_ad_oe),
    .host_ad_oe(bus.host_ad_oe), .dev_frame_n_oe(bus.dev_frame_n_oe),
    .host_frame_n_oe(bus.host_frame_n_oe), .dev_devsel_n_oe(bus.dev_devsel_n_oe));
  always #20 sys_clk = ~sys_clk;
  // link clock with an odd start so its edges never line up with sys_clk
  initial #3 forever #15 pci_clk = ~pci_clk;
  always @(posedge sys_clk) if (tgt_wr_valid === 1'b1) begin
    wr_a <= tgt_wr_addr;
    wr_d <= tgt_wr_data;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic dev_op(input logic [3:0] c, input logic [31:0] a, d, input logic [3:0] be);
    int n;
    @(posedge sys_clk);
    usr_start <= 1'b1;
    usr_cmd <= c;
    usr_addr <= a;
    usr_wdata <= d;
    usr_be_n <= be;
    @(posedge sys_clk);
    usr_start <= 1'b0;
    #1;
    chk("usr_busy", 32'h1, {31'h0, usr_busy});
    for (n = 0; n < 400 && usr_done !== 1'b1; n++) @(posedge sys_clk) #1;
    chk("usr_done", 32'h1, {31'h0, usr_done});
    chk("usr_busy", 32'h0, {31'h0, usr_busy});
  endtask : dev_op
  task automatic host_op(input logic [3:0] c, input logic [31:0] a, d, input logic [3:0] be);
    int n;
    @(posedge pci_clk);
    h_start <= 1'b1;
    h_cmd <= c;
    h_addr <= a;
    h_wdata <= d;
    h_be_n <= be;
    @(posedge pci_clk);
    h_start <= 1'b0;
    #1;
    chk("h_busy", 32'h1, {31'h0, h_busy});
    for (n = 0; n < 400 && h_done !== 1'b1; n++) @(posedge pci_clk) #1;
    chk("h_done", 32'h1, {31'h0, h_done});
    chk("h_busy", 32'h0, {31'h0, h_busy});
  endtask : host_op
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // under 20 transfers of under 40 link cycles each; ten times that is the limit
  initial begin
    #240000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    #7 rst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      host_op(`PCS_CMD_CFG_WR, 32'(i * 4), 32'h5a00_0000 + 32'(i), 4'h0);
      host_op(`PCS_CMD_CFG_RD, 32'(i * 4), 32'h0, 4'h0);
      chk("cfg word", 32'h5a00_0000 + 32'(i), h_rdata);
    end
    $display("test config words done");
    host_op(`PCS_CMD_MEM_WR, BASE + 32'h8, 32'hc0de_0001, 4'h0);
    repeat (8) @(posedge sys_clk);
    chk("tgt_wr_addr", BASE + 32'h8, wr_a);
    chk("tgt_wr_data", 32'hc0de_0001, wr_d);
    host_op(`PCS_CMD_MEM_RD, BASE + 32'h8, 32'h0, 4'h0);
    chk("mem word", 32'hc0de_0001, h_rdata);
    chk("h_sts", 32'h0, {29'h0, h_sts});
    // one line above the device window: nobody selects, so the host master gives up
    host_op(`PCS_CMD_MEM_RD, BASE + 32'h10, 32'h0, 4'h0);
    chk("h_sts miss", 32'h1 << `PCS_STS_ABORT, {29'h0, h_sts});
    $display("test device target done");
    dev_op(`PCS_CMD_MEM_WR, 32'h4, 32'haabb_ccdd, 4'h0);
    dev_op(`PCS_CMD_MEM_WR, 32'h4, 32'h1122_3344, 4'hc);
    dev_op(`PCS_CMD_MEM_RD, 32'h4, 32'h0, 4'h0);
    chk("usr_rdata", 32'haabb_3344, usr_rdata);
    chk("usr_sts", 32'h0, {29'h0, usr_sts});
    // the host target never answers config cycles, so this must end in an abort
    dev_op(`PCS_CMD_CFG_RD, 32'h0, 32'h0, 4'h0);
    chk("usr_sts abort", 32'h1 << `PCS_STS_ABORT, {29'h0, usr_sts});
    $display("test device master done");
    finish_test();
  end
endmodule : tb_top
